// ### verilog/motion_protection_interlock.sv
// Purpose: amplifier enable, error output and limit/abort interlock for one axis
// Assumes: pins are asynchronous; command strobes come from core_clk logic
// Notes: all outputs registered; amplifier stays off from reset until servo-here
// How it works
// - a motor-off command turns the amplifier enable off.
// - position error magnitude above the error limit turns the amplifier off.
// - abort command with off-on-error enabled turns the amplifier off.
// - watchdog trip or reset holds the amplifier enable low.
// - error output goes low and the lamp lights while any error exists.
// - abort input low kills commanded motion at once, no ramp.
// - abort with off-on-error enabled disables the amplifier.
// - abort with off-on-error disabled stops and holds servo at present position.
// - abort halts the program unless the fifth config field says continue.
// - electronic lockout forces the amplifier off, no software override.
// - forward limit inhibits forward motion and ramps forward motion to stop.
// - forward limit hit while moving forward requests the limit handler, if defined.
// - reverse limit inhibits reverse motion and ramps reverse motion to stop.
// - reverse limit hit while moving reverse requests the limit handler, if defined.
// - limit polarity comes from the config setting; active low by default.
// - off-on-error set for limits makes an active limit disable the amplifier.
// - error limit resets to 16384 counts and holds 0 to 2147483647.
// - off-on-error values 1, 2, 3 enable it; 0 disables it.
module motion_protection_interlock
   import motion_protection_pkg::*;
(
   input wire logic core_clk, // 40 MHz core clock
   input wire logic srst, // synchronous reset, active high
   input wire logic motor_off_cmd, // pulse: motor-off command
   input wire logic servo_here_cmd, // pulse: re-enable amplifier
   input wire logic abort_cmd, // pulse: software abort
   input wire logic watchdog_trip, // level: watchdog tripped
   input wire logic [31:0] position_error, // signed axis position error
   input wire logic err_limit_wr, // pulse: load error limit
   input wire logic [30:0] err_limit_data, // new error limit
   input wire logic in_cfg_wr, // pulse: load input configuration
   input wire logic [4:0] in_cfg_data, // new input configuration
   input wire logic oe_wr, // pulse: load off-on-error setting
   input wire logic [1:0] oe_data, // new off-on-error value
   input wire logic abort_n_pin, // general abort pin, active low
   input wire logic electronic_lockout_input, // lockout pin, active high
   input wire logic fwd_limit_pin, // forward limit switch pin
   input wire logic rev_limit_pin, // reverse limit switch pin
   input wire logic moving_fwd, // profiler moving forward
   input wire logic moving_rev, // profiler moving reverse
   input wire logic limit_switch_handler, // handler routine exists
   output logic amp_enable, // amplifier enable, high = on
   output logic error_n, // error output, active low
   output logic error_lamp, // error lamp drive
   output logic motion_kill, // abrupt stop of commanded motion
   output logic servo_hold, // hold servo at present position
   output logic decel_stop, // ramped stop request
   output logic inhibit_fwd, // forward motion blocked
   output logic inhibit_rev, // reverse motion blocked
   output logic limit_handler_req, // pulse: enter limit handler
   output logic program_halt, // pulse: halt program execution
   output logic [30:0] error_limit_setting, // current error limit
   output logic [4:0] input_configuration_setting, // current config
   output logic [1:0] off_on_error // current off-on-error value
);

   // ==========================================
   // pin synchronisers
   logic [SYNC_W-1:0] pin_raw;
   logic [SYNC_W-1:0] sync_a;
   logic [SYNC_W-1:0] sync_b;
   assign pin_raw = {rev_limit_pin, fwd_limit_pin, electronic_lockout_input, abort_n_pin};

   genvar g;
   generate
      for (g = 0; g < SYNC_W; g++) begin : g_sync
         always_ff @(posedge core_clk) begin
            sync_a[g] <= pin_raw[g];
            sync_b[g] <= sync_a[g];
         end
      end
   endgenerate

   // limit pins read high when idle on active-low switches
   function automatic logic limit_active(input logic level, input logic high_true);
      limit_active = high_true ? level : ~level;
   endfunction

   // ==========================================
   // settings
   always_ff @(posedge core_clk) begin
      if (srst) begin
         error_limit_setting <= ERR_LIMIT_RESET;
         input_configuration_setting <= IN_CFG_RESET;
         off_on_error <= OFF_ON_ERR_RESET;
      end else begin
         if (err_limit_wr) begin
            error_limit_setting <= err_limit_data;
         end
         if (in_cfg_wr) begin
            input_configuration_setting <= in_cfg_data;
         end
         if (oe_wr) begin
            off_on_error <= oe_data;
         end
      end
   end

   // ==========================================
   // decode
   logic cfg_limit_high;
   logic cfg_abort_cont;
   logic oe_on;
   logic oe_limit;
   logic abort_active;
   logic lockout_active;
   logic fwd_active;
   logic rev_active;
   logic [32:0] err_mag;
   logic pos_exceed;
   logic abort_any;
   logic limit_hit;
   logic err_cond;

   assign cfg_limit_high = input_configuration_setting[CFG_LIMIT_HIGH_BIT];
   assign cfg_abort_cont = input_configuration_setting[CFG_ABORT_CONT_BIT];
   assign oe_on = (off_on_error != 2'h0);
   assign oe_limit = off_on_error[OE_LIMIT_OFF_BIT];
   assign abort_active = ~sync_b[SYNC_ABORT];
   assign lockout_active = sync_b[SYNC_LOCKOUT];
   assign fwd_active = limit_active(sync_b[SYNC_FWD], cfg_limit_high);
   assign rev_active = limit_active(sync_b[SYNC_REV], cfg_limit_high);
   // 33 bits so that the most negative error still has a true magnitude
   assign err_mag = position_error[31] ? (33'h0_0000_0000 - {position_error[31], position_error})
                                       : {1'b0, position_error};
   assign pos_exceed = (err_mag > {2'h0, error_limit_setting});
   assign abort_any = abort_active | abort_cmd;
   assign limit_hit = (fwd_active & moving_fwd) | (rev_active & moving_rev);
   assign err_cond = pos_exceed | watchdog_trip | abort_active | lockout_active;

   // ==========================================
   // amplifier enable
   amp_state_t amp_state;
   amp_state_t next_amp;
   logic amp_kill;
   assign amp_kill = motor_off_cmd
                   | pos_exceed
                   | (oe_on & abort_cmd)
                   | watchdog_trip
                   | (oe_on & abort_active)
                   | lockout_active
                   | (oe_limit & (fwd_active | rev_active));

   // any off cause beats a servo-here in the same cycle
   always_comb begin
      case (amp_state)
         AMP_OFF: next_amp = (servo_here_cmd && !amp_kill) ? AMP_ON : AMP_OFF;
         AMP_ON: next_amp = amp_kill ? AMP_OFF : AMP_ON;
         default: next_amp = AMP_OFF;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         amp_state <= AMP_OFF;
         amp_enable <= 1'b0;
      end else begin
         amp_state <= next_amp;
         amp_enable <= (next_amp == AMP_ON);
      end
   end

   // ==========================================
   // error output, abort and limit outputs
   logic abort_prev;
   logic hit_prev;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         error_n <= 1'b1;
         error_lamp <= 1'b0;
         motion_kill <= 1'b0;
         servo_hold <= 1'b0;
         decel_stop <= 1'b0;
         inhibit_fwd <= 1'b0;
         inhibit_rev <= 1'b0;
         limit_handler_req <= 1'b0;
         program_halt <= 1'b0;
         abort_prev <= 1'b0;
         hit_prev <= 1'b0;
      end else begin
         error_n <= ~err_cond;
         error_lamp <= err_cond;
         motion_kill <= abort_any;
         servo_hold <= abort_any & ~oe_on;
         decel_stop <= limit_hit;
         inhibit_fwd <= fwd_active;
         inhibit_rev <= rev_active;
         // one request per hit, not one per cycle the switch stays made
         limit_handler_req <= limit_hit & ~hit_prev & limit_switch_handler;
         program_halt <= abort_any & ~abort_prev & ~cfg_abort_cont;
         abort_prev <= abort_any;
         hit_prev <= limit_hit;
      end
   end

   // ==========================================
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   chk_motor_off_amp: assert property (motor_off_cmd |=> !amp_enable)
      else $error("amp enable stayed high after motor off");
   chk_pos_err_amp: assert property (pos_exceed |=> !amp_enable && !error_n)
      else $error("excess position error did not drop amp enable");
   chk_abort_cmd_amp: assert property (abort_cmd && oe_on |=> !amp_enable)
      else $error("abort command with off-on-error left amp on");
   chk_watchdog_amp: assert property (watchdog_trip |=> !amp_enable)
      else $error("watchdog trip left amp on");
   chk_reset_amp: assert property (@(posedge core_clk) disable iff (1'b0)
      srst |=> !amp_enable)
      else $error("amp enable high right after reset");
   chk_error_lamp_pair: assert property (err_cond |=> !error_n && error_lamp)
      else $error("error output or lamp wrong during error");
   chk_abort_pin_kill: assert property (!abort_n_pin ##1 !abort_n_pin ##1 !abort_n_pin
      |=> motion_kill)
      else $error("abort pin low did not kill motion");
   chk_abort_oe_amp: assert property (abort_active && oe_on |=> !amp_enable)
      else $error("abort with off-on-error left amp on");
   chk_abort_hold: assert property (abort_active && !oe_on |=> servo_hold && motion_kill)
      else $error("abort without off-on-error did not hold servo");
   chk_abort_halt: assert property (abort_any && !abort_prev |=> program_halt == !$past(cfg_abort_cont))
      else $error("program halt wrong on abort");
   chk_lockout_amp: assert property (lockout_active |=> !amp_enable[*2])
      else $error("lockout did not hold amp off");
   chk_fwd_limit: assert property (fwd_active && moving_fwd |=> inhibit_fwd && decel_stop)
      else $error("forward limit did not inhibit and stop");
   chk_rev_limit: assert property (rev_active && moving_rev |=> inhibit_rev && decel_stop)
      else $error("reverse limit did not inhibit and stop");
   chk_limit_handler: assert property (limit_hit && !hit_prev && limit_switch_handler
      |=> limit_handler_req ##1 !limit_handler_req)
      else $error("limit handler request missing or too long");
   chk_no_handler: assert property (!limit_switch_handler |=> !limit_handler_req)
      else $error("handler request with no handler");
   chk_limit_oe_amp: assert property (oe_limit && (fwd_active || rev_active) |=> !amp_enable)
      else $error("limit with off-on-error left amp on");

   cov_abort_hold: cover property (abort_active && !oe_on ##1 servo_hold);
   cov_handler: cover property (limit_handler_req);
   cov_amp_on: cover property (!amp_enable ##1 amp_enable);
   cov_pos_err_trip: cover property (amp_enable ##1 pos_exceed ##1 !amp_enable);

   // ==========================================
   // settings loads
   chk_err_limit_load: assert property (err_limit_wr |=> error_limit_setting == $past(err_limit_data))
      else $error("error limit write did not land");
   chk_cfg_load: assert property (in_cfg_wr |=> input_configuration_setting == $past(in_cfg_data))
      else $error("input configuration write did not land");
   chk_oe_load: assert property (oe_wr |=> off_on_error == $past(oe_data))
      else $error("off-on-error write did not land");
   chk_err_limit_hold: assert property (!err_limit_wr |=> $stable(error_limit_setting))
      else $error("error limit moved without a write");
   chk_cfg_hold: assert property (!in_cfg_wr |=> $stable(input_configuration_setting))
      else $error("input configuration moved without a write");
   chk_oe_hold: assert property (!oe_wr |=> $stable(off_on_error))
      else $error("off-on-error moved without a write");

   // ==========================================
   // amplifier latch
   chk_servo_here_on: assert property (servo_here_cmd && !amp_kill |=> amp_enable)
      else $error("servo here with no off cause left amp off");
   chk_servo_here_refused: assert property (servo_here_cmd && amp_kill |=> !amp_enable)
      else $error("servo here overrode an off cause");
   // amp only comes back through servo-here, never on its own
   chk_amp_latched: assert property (!amp_enable && !servo_here_cmd |=> !amp_enable)
      else $error("amp came on without servo here");
   chk_amp_stays_on: assert property (amp_enable && !amp_kill |=> amp_enable)
      else $error("amp dropped with no off cause");
   chk_zero_limit: assert property (error_limit_setting == 31'h0000_0000 && position_error != 32'h0000_0000
      |=> !amp_enable)
      else $error("nonzero error against zero limit left amp on");
   chk_most_negative: assert property (position_error == 32'h8000_0000 |=> !amp_enable && !error_n)
      else $error("most negative position error not caught");
   chk_oe_off_no_limit: assert property (!oe_limit && !motor_off_cmd && !pos_exceed && !watchdog_trip
      && !abort_any && !lockout_active && amp_enable |=> amp_enable)
      else $error("limit dropped amp with limit disabling off");

   // ==========================================
   // error output and abort
   chk_lamp_mirror: assert property (error_lamp == !error_n)
      else $error("error lamp and error output disagree");
   chk_err_clear: assert property (!err_cond |=> error_n && !error_lamp)
      else $error("error output stayed active with no error");
   chk_watchdog_err: assert property (watchdog_trip |=> !error_n)
      else $error("watchdog trip not shown on error output");
   chk_abort_pin_err: assert property (abort_active |=> error_lamp)
      else $error("abort pin not shown on error lamp");
   chk_lockout_err: assert property (lockout_active |=> !error_n && error_lamp)
      else $error("lockout not shown on error output");
   chk_cmd_kill: assert property (abort_cmd |=> motion_kill)
      else $error("abort command did not kill motion");
   chk_kill_clear: assert property (!abort_any |=> !motion_kill && !servo_hold)
      else $error("motion kill without abort");
   chk_hold_oe: assert property (oe_on |=> !servo_hold)
      else $error("servo hold while off-on-error enabled");
   chk_abort_cont: assert property (cfg_abort_cont |=> !program_halt)
      else $error("program halted while abort continue set");
   chk_halt_pulse: assert property (program_halt |=> !program_halt)
      else $error("program halt longer than one cycle");

   // ==========================================
   // limits
   chk_fwd_inhibit: assert property (fwd_active |=> inhibit_fwd)
      else $error("active forward limit not inhibiting");
   chk_fwd_release: assert property (!fwd_active |=> !inhibit_fwd)
      else $error("forward inhibit without active limit");
   chk_rev_inhibit: assert property (rev_active |=> inhibit_rev)
      else $error("active reverse limit not inhibiting");
   chk_rev_release: assert property (!rev_active |=> !inhibit_rev)
      else $error("reverse inhibit without active limit");
   chk_decel_release: assert property (!limit_hit |=> !decel_stop)
      else $error("ramped stop with no limit hit");
   chk_rev_handler: assert property (rev_active && moving_rev && !hit_prev && limit_switch_handler
      |=> limit_handler_req)
      else $error("reverse limit hit did not request handler");
   chk_handler_once: assert property (limit_handler_req |=> !limit_handler_req)
      else $error("handler request longer than one cycle");
   // high polarity with an idle-low pin must not read as a hit
   chk_polarity_high: assert property (cfg_limit_high && !sync_b[SYNC_FWD] |-> !fwd_active)
      else $error("forward limit polarity ignored");
   chk_polarity_low: assert property (!cfg_limit_high && sync_b[SYNC_REV] |-> !rev_active)
      else $error("reverse limit polarity ignored");
   chk_limit_oe_rev: assert property (oe_limit && rev_active |=> !amp_enable)
      else $error("reverse limit with limit disabling left amp on");

   cov_lockout: cover property (amp_enable ##1 lockout_active ##1 !amp_enable);

   // ==========================================
   // synchroniser
   // both stages must be in the path, or a metastable level reaches the decode
   chk_sync_first: assert property (sync_a == $past(pin_raw))
      else $error("synchroniser first stage skipped");
   chk_sync_chain: assert property (sync_b == $past(sync_a))
      else $error("synchroniser second stage skipped");

endmodule

// ### common/motion_protection_pkg.sv
// Purpose: shared constants for the motion protection interlock
// Assumes: one axis, 40 MHz core clock
// Notes: settings are loaded through write strobes on plain ports
package motion_protection_pkg;
   // ==========================================
   // reset values
   localparam logic [30:0] ERR_LIMIT_RESET = 31'h0000_4000;
   localparam logic [4:0] IN_CFG_RESET = 5'h00;
   localparam logic [1:0] OFF_ON_ERR_RESET = 2'h0;
   // ==========================================
   // input configuration field positions
   localparam int CFG_LIMIT_HIGH_BIT = 0;
   localparam int CFG_ABORT_CONT_BIT = 4;
   // ==========================================
   // off-on-error field positions
   localparam int OE_LIMIT_OFF_BIT = 1;
   // ==========================================
   // synchroniser vector layout
   localparam int SYNC_ABORT = 0;
   localparam int SYNC_LOCKOUT = 1;
   localparam int SYNC_FWD = 2;
   localparam int SYNC_REV = 3;
   localparam int SYNC_W = 4;
   typedef enum logic {
      AMP_OFF = 1'b0,
      AMP_ON = 1'b1
   } amp_state_t;
endpackage

// ### bench/switch_model.sv
// Purpose: abort, lockout and limit switches wired to the interlock
// Assumes: the bench moves switches just after a core_clk edge
// Notes: contacts are ideal, no bounce; limit wiring polarity is selectable
module switch_model (
   input wire logic abort_on, // abort switch pressed
   input wire logic lock_on, // lockout asserted
   input wire logic fwd_on, // forward limit reached
   input wire logic rev_on, // reverse limit reached
   input wire logic lim_high, // limits wired active high
   output logic abort_n_pin, // abort pin, low when pressed
   output logic lockout_pin, // lockout pin, high when asserted
   output logic fwd_limit_pin, // forward limit contact
   output logic rev_limit_pin // reverse limit contact
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================
   // wiring
   assign abort_n_pin = !abort_on;
   assign lockout_pin = lock_on;
   // an idle contact sits at the opposite of its active level
   assign fwd_limit_pin = fwd_on ~^ lim_high;
   assign rev_limit_pin = rev_on ~^ lim_high;
endmodule

// ### bench/tb_motion_protection_interlock.sv
// Purpose: self-checking bench for the motion protection interlock
// Assumes: inputs move 1 ns after each core_clk rise
// Notes: pin effects are checked three edges after the pin moves
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
   $display("BAD %s exp %h got %h", n, e, g); err_total++; end end
module tb_motion_protection_interlock;
   import motion_protection_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================
   // signals
   logic core_clk, srst = 1, motor_off_cmd = 0, servo_here_cmd = 0, abort_cmd = 0, watchdog_trip = 0;
   logic [31:0] position_error = 0;
   logic err_limit_wr = 0, in_cfg_wr = 0, oe_wr = 0, moving_fwd = 0, moving_rev = 0;
   logic [30:0] err_limit_data = 0;
   logic [4:0] in_cfg_data = 0;
   logic [1:0] oe_data = 0;
   logic limit_switch_handler = 0, abort_on = 0, lock_on = 0, fwd_on = 0, rev_on = 0, lim_high = 0;
   logic abort_n_pin, lockout_pin, fwd_limit_pin, rev_limit_pin;
   logic amp_enable, error_n, error_lamp, motion_kill, servo_hold, decel_stop;
   logic inhibit_fwd, inhibit_rev, limit_handler_req, program_halt;
   logic [30:0] error_limit_setting;
   logic [4:0] input_configuration_setting;
   logic [1:0] off_on_error;
   int err_total = 0, num_checks = 0, cycles = 0;
   motion_protection_interlock DUT (.core_clk, .srst, .motor_off_cmd, .servo_here_cmd, .abort_cmd,
      .watchdog_trip, .position_error, .err_limit_wr, .err_limit_data, .in_cfg_wr, .in_cfg_data, .oe_wr,
      .oe_data, .abort_n_pin, .electronic_lockout_input(lockout_pin), .fwd_limit_pin, .rev_limit_pin,
      .moving_fwd, .moving_rev, .limit_switch_handler, .amp_enable, .error_n, .error_lamp, .motion_kill,
      .servo_hold, .decel_stop, .inhibit_fwd, .inhibit_rev, .limit_handler_req, .program_halt,
      .error_limit_setting, .input_configuration_setting, .off_on_error);
   switch_model far_side (.abort_on, .lock_on, .fwd_on, .rev_on, .lim_high, .abort_n_pin, .lockout_pin,
      .fwd_limit_pin, .rev_limit_pin);
   // ==========================================
   // helpers
   initial begin
      core_clk = 0;
      forever #12.5 core_clk = ~core_clk;
   end
   // ceiling well above the 62 cycles the scenarios need
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         end_of_test();
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic pulse(ref logic s);
      s = 1;
      step(1);
      s = 0;
   endtask
   task automatic end_of_test;
      if (err_total == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ==========================================
   // scenarios
   task automatic t_reset;
      `CHK("amp_enable", 1'b0, amp_enable)
      `CHK("error_n", 1'b1, error_n)
      `CHK("error_limit_setting", 31'h0000_4000, error_limit_setting)
      `CHK("off_on_error", 2'h0, off_on_error)
      `CHK("input_configuration_setting", 5'h00, input_configuration_setting)
   endtask
   task automatic t_commands;
      pulse(servo_here_cmd);
      `CHK("amp_enable", 1'b1, amp_enable)
      pulse(motor_off_cmd);
      `CHK("amp_enable", 1'b0, amp_enable)
      pulse(servo_here_cmd);
      watchdog_trip = 1;
      step(1);
      `CHK("amp_enable", 1'b0, amp_enable)
      pulse(servo_here_cmd);
      step(1);
      `CHK("amp_enable", 1'b0, amp_enable)
      `CHK("error_n", 1'b0, error_n)
      watchdog_trip = 0;
      step(2);
   endtask
   task automatic t_pos_err;
      err_limit_data = 31'h7fff_ffff;
      pulse(err_limit_wr);
      `CHK("error_limit_setting", 31'h7fff_ffff, error_limit_setting)
      err_limit_data = 31'h0000_0064;
      pulse(err_limit_wr);
      position_error = 32'hffff_ff9c;
      step(1);
      pulse(servo_here_cmd);
      `CHK("amp_enable", 1'b1, amp_enable)
      position_error = 32'hffff_ff9b;
      step(2);
      `CHK("amp_enable", 1'b0, amp_enable)
      `CHK("error_lamp", 1'b1, error_lamp)
      position_error = 0;
      step(2);
      `CHK("error_n", 1'b1, error_n)
   endtask
   task automatic t_abort;
      pulse(servo_here_cmd);
      abort_on = 1;
      step(2);
      `CHK("motion_kill", 1'b0, motion_kill)
      step(1);
      `CHK("motion_kill", 1'b1, motion_kill)
      `CHK("servo_hold", 1'b1, servo_hold)
      `CHK("program_halt", 1'b1, program_halt)
      `CHK("amp_enable", 1'b1, amp_enable)
      `CHK("error_n", 1'b0, error_n)
      step(1);
      `CHK("program_halt", 1'b0, program_halt)
      abort_on = 0;
      oe_data = 2'h1;
      pulse(oe_wr);
      `CHK("off_on_error", 2'h1, off_on_error)
      in_cfg_data = 5'h10;
      pulse(in_cfg_wr);
      step(3);
      pulse(servo_here_cmd);
      `CHK("amp_enable", 1'b1, amp_enable)
      pulse(abort_cmd);
      `CHK("amp_enable", 1'b0, amp_enable)
      `CHK("servo_hold", 1'b0, servo_hold)
      `CHK("program_halt", 1'b0, program_halt)
      step(1);
   endtask
   task automatic t_lockout;
      pulse(servo_here_cmd);
      lock_on = 1;
      step(3);
      `CHK("amp_enable", 1'b0, amp_enable)
      pulse(servo_here_cmd);
      `CHK("amp_enable", 1'b0, amp_enable)
      lock_on = 0;
      step(3);
   endtask
   task automatic t_limits;
      oe_data = 2'h0;
      pulse(oe_wr);
      in_cfg_data = 5'h00;
      pulse(in_cfg_wr);
      moving_fwd = 1;
      limit_switch_handler = 1;
      fwd_on = 1;
      step(2);
      `CHK("inhibit_fwd", 1'b0, inhibit_fwd)
      step(1);
      `CHK("inhibit_fwd", 1'b1, inhibit_fwd)
      `CHK("decel_stop", 1'b1, decel_stop)
      `CHK("limit_handler_req", 1'b1, limit_handler_req)
      step(1);
      `CHK("limit_handler_req", 1'b0, limit_handler_req)
      {fwd_on, moving_fwd, limit_switch_handler, moving_rev, rev_on} = 5'h03;
      step(3);
      `CHK("inhibit_rev", 1'b1, inhibit_rev)
      `CHK("decel_stop", 1'b1, decel_stop)
      `CHK("limit_handler_req", 1'b0, limit_handler_req)
      {moving_rev, rev_on, lim_high, in_cfg_data, oe_data} = {3'h1, 5'h01, 2'h2};
      pulse(in_cfg_wr);
      pulse(oe_wr);
      pulse(servo_here_cmd);
      step(3);
      `CHK("amp_enable", 1'b1, amp_enable)
      fwd_on = 1;
      step(3);
      `CHK("inhibit_fwd", 1'b1, inhibit_fwd)
      `CHK("amp_enable", 1'b0, amp_enable)
      `CHK("decel_stop", 1'b0, decel_stop)
   endtask
   // ==========================================
   // main sequence
   initial begin
      step(6);
      t_reset();
      srst = 0;
      step(1);
      t_commands();
      t_pos_err();
      t_abort();
      t_lockout();
      t_limits();
      end_of_test();
   end
endmodule
